// ==== verilog/mirl_regs.vh ====
`ifndef MIRL_REGS_VH
`define MIRL_REGS_VH
// source indices in fixed polling order, 0 wins among equals
`define MIRL_NSRC        10
`define MIRL_SRC_EXT0    4'h0
`define MIRL_SRC_UART2   4'h1
`define MIRL_SRC_TMR0    4'h2
`define MIRL_SRC_TWB     4'h3
`define MIRL_SRC_EXT1    4'h4
`define MIRL_SRC_DDC     4'h5
`define MIRL_SRC_TMR1    4'h6
`define MIRL_SRC_USB     4'h7
`define MIRL_SRC_UART1   4'h8
`define MIRL_SRC_TMR2    4'h9
// synchronised pins are asserted high, so idle after reset is all low
`define MIRL_PIN_IDLE    3'h0
// timer 0 mode in which its overflow requests nothing
`define MIRL_T0_MODE3    2'h3
`endif

// ==== verilog/mirl_sync.v ====
`timescale 1ns/1ps
// ==========================================
// two flip-flop synchroniser, one per bit
module mirl_sync #(
   parameter WIDTH = 3
) (
   // clock and reset
   input  wire             clk_sys,
   input  wire             nrst,
   // data
   input  wire [WIDTH-1:0] din,
   output reg  [WIDTH-1:0] dout
);
   reg [WIDTH-1:0] stage1;  // first stage, read only by dout

   // two stages per bit
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_bit
         always @(posedge clk_sys or negedge nrst)
         begin
            if (!nrst)
            begin
               stage1[i] <= 1'b0;
               dout[i]   <= 1'b0;
            end
            else
            begin
               stage1[i] <= din[i];
               dout[i]   <= stage1[i];
            end
         end
      end
   endgenerate
endmodule // mirl_sync

// ==== verilog/mirl_irq_logic.v ====
// What this block does
// - ten request sources feed the controller
// - converter-done shares external request one input
// - ext zero sensed by level or falling edge
// - vector clears ext flag only in edge mode or converter mode
// - level mode flag follows pin, no ack clear
// - timer overflows request, not timer0 mode three
// - timer zero/one flags cleared on vector
// - timer two overflow cleared by software only
// - timer two trigger gated, latched in flag
// - two levels; high preempts low, not reverse
// - equal level: fixed polling order, zero first
// - individual enables plus global enable gate
`timescale 1ns/1ps
`include "mirl_regs.vh"
module mirl_irq_logic #(
   parameter NSRC = `MIRL_NSRC
) (
   // clock and reset
   input  wire            clk_sys,
   input  wire            nrst,
   // external pins, active low, asynchronous
   input  wire            ext_request_zero_n,
   input  wire            ext_request_one_n,
   input  wire            timer_two_ext_trigger_n,
   // trigger configuration
   input  wire            ext0_trigger_type,
   input  wire            ext1_trigger_type,
   input  wire            adc_takes_ext1,
   input  wire            adc_done,
   // timer events from same clock domain
   input  wire            timer_zero_overflow,
   input  wire [1:0]      timer_zero_mode,
   input  wire            timer_one_overflow,
   input  wire            timer_two_overflow,
   input  wire            timer_two_ext_trigger_enable,
   // software clears of the timer two flags
   input  wire            timer_two_overflow_clr,
   input  wire            timer_two_ext_trigger_clr,
   // peripheral request levels, cleared at their sources
   input  wire            uart2_req,
   input  wire            twb_req,
   input  wire            ddc_req,
   input  wire            usb_req,
   input  wire            uart1_req,
   // enables and priorities, bit per source index
   input  wire [NSRC-1:0] irq_enable_bits,
   input  wire            global_irq_enable,
   input  wire [NSRC-1:0] irq_priority_bits,
   // core handshake
   input  wire            core_vector_ack,
   input  wire            core_return,
   // flags and request to the core
   output reg             ext0_pending_flag,
   output reg             ext1_pending_flag,
   output reg             timer_zero_overflow_flag,
   output reg             timer_one_overflow_flag,
   output reg             timer_two_overflow_flag,
   output reg             timer_two_ext_trigger_flag,
   output wire            irq_request,
   output wire [3:0]      irq_source,
   output wire            irq_high_level,
   output reg             in_service_low,
   output reg             in_service_high
);
   // ==========================================
   // pin synchronisation
   wire [2:0] pin_sync;     // synchronised pins, inverted so asserted is high
   reg  [2:0] pin_prev;     // previous synchronised values

   mirl_sync #(
      .WIDTH (3)
   ) u_sync (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      // inverted ahead of the stages so the reset value matches an idle pin
      .din     ({~timer_two_ext_trigger_n, ~ext_request_one_n, ~ext_request_zero_n}),
      .dout    (pin_sync)
   );

   // edge history of synchronised pins
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
         pin_prev <= `MIRL_PIN_IDLE;
      else
         pin_prev <= pin_sync;
   end

   wire ext0_fall = ~pin_prev[0] & pin_sync[0];   // pin fall on ext zero
   wire ext1_fall = ~pin_prev[1] & pin_sync[1];   // pin fall on ext one
   wire timer_two_ext_trigger_fall = ~pin_prev[2] & pin_sync[2];   // pin fall on timer two trigger

   // ==========================================
   // arbitration
   wire [NSRC-1:0] pend;       // raw pending per source
   wire [NSRC-1:0] en_pend;    // enabled and pending
   reg  [3:0]      win_idx;    // winning source
   reg             win_hi;     // winner is high level
   reg             win_ok;     // a winner is allowed
   reg             found_hi;   // high level request seen
   reg             found_lo;   // low level request seen
   reg  [3:0]      lo_idx;     // best low request
   reg  [3:0]      hi_idx;     // best high request
   integer         k;

   assign pend[`MIRL_SRC_EXT0]  = ext0_pending_flag;
   assign pend[`MIRL_SRC_UART2] = uart2_req;
   assign pend[`MIRL_SRC_TMR0]  = timer_zero_overflow_flag;
   assign pend[`MIRL_SRC_TWB]   = twb_req;
   assign pend[`MIRL_SRC_EXT1]  = ext1_pending_flag;
   assign pend[`MIRL_SRC_DDC]   = ddc_req;
   assign pend[`MIRL_SRC_TMR1]  = timer_one_overflow_flag;
   assign pend[`MIRL_SRC_USB]   = usb_req;
   assign pend[`MIRL_SRC_UART1] = uart1_req;
   assign pend[`MIRL_SRC_TMR2]  = timer_two_overflow_flag | timer_two_ext_trigger_flag;

   assign en_pend = pend & irq_enable_bits & {NSRC{global_irq_enable}};

   // lowest index wins within each level, high level wins overall
   always @*
   begin
      found_hi = 1'b0;
      found_lo = 1'b0;
      hi_idx   = 4'h0;
      lo_idx   = 4'h0;
      for (k = NSRC - 1; k >= 0; k = k - 1)
      begin
         if (en_pend[k] && irq_priority_bits[k])
         begin
            found_hi = 1'b1;
            hi_idx   = k[3:0];
         end
         else if (en_pend[k])
         begin
            found_lo = 1'b1;
            lo_idx   = k[3:0];
         end
      end
      win_hi  = found_hi;
      win_idx = found_hi ? hi_idx : lo_idx;
      // nothing preempts high; high preempts low only
      if (in_service_high)
         win_ok = 1'b0;
      else if (in_service_low)
         win_ok = found_hi;
      else
         win_ok = found_hi | found_lo;
   end

   assign irq_request    = win_ok;
   assign irq_source     = win_idx;
   assign irq_high_level = win_hi;

   wire take = core_vector_ack & win_ok;   // vector taken this cycle
   wire ack0 = take && (win_idx == `MIRL_SRC_EXT0);
   wire ack1 = take && (win_idx == `MIRL_SRC_EXT1);
   wire ackt0 = take && (win_idx == `MIRL_SRC_TMR0);
   wire ackt1 = take && (win_idx == `MIRL_SRC_TMR1);

   // ==========================================
   // flag registers, a set always beats a clear
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         ext0_pending_flag          <= 1'b0;
         ext1_pending_flag          <= 1'b0;
         timer_zero_overflow_flag   <= 1'b0;
         timer_one_overflow_flag    <= 1'b0;
         timer_two_overflow_flag    <= 1'b0;
         timer_two_ext_trigger_flag <= 1'b0;
      end
      else
      begin
         // ext zero: level follows pin, edge latched until vector
         if (!ext0_trigger_type)
            ext0_pending_flag <= pin_sync[0];
         else if (ext0_fall)
            ext0_pending_flag <= 1'b1;
         else if (ack0)
            ext0_pending_flag <= 1'b0;
         // ext one: adc completion may stand in for the pin
         if (adc_takes_ext1)
         begin
            if (adc_done)
               ext1_pending_flag <= 1'b1;
            else if (ack1)
               ext1_pending_flag <= 1'b0;
         end
         else if (!ext1_trigger_type)
            ext1_pending_flag <= pin_sync[1];
         else if (ext1_fall)
            ext1_pending_flag <= 1'b1;
         else if (ack1)
            ext1_pending_flag <= 1'b0;
         // timer zero overflow, silent in mode three
         if (timer_zero_overflow && (timer_zero_mode != `MIRL_T0_MODE3))
            timer_zero_overflow_flag <= 1'b1;
         else if (ackt0)
            timer_zero_overflow_flag <= 1'b0;
         // timer one overflow
         if (timer_one_overflow)
            timer_one_overflow_flag <= 1'b1;
         else if (ackt1)
            timer_one_overflow_flag <= 1'b0;
         // timer two overflow, software clear only
         if (timer_two_overflow)
            timer_two_overflow_flag <= 1'b1;
         else if (timer_two_overflow_clr)
            timer_two_overflow_flag <= 1'b0;
         // timer two external trigger
         if (timer_two_ext_trigger_fall && timer_two_ext_trigger_enable)
            timer_two_ext_trigger_flag <= 1'b1;
         else if (timer_two_ext_trigger_clr)
            timer_two_ext_trigger_flag <= 1'b0;
      end
   end

   // ==========================================
   // in-service levels, set on vector, cleared on return
   always @(posedge clk_sys or negedge nrst)
   begin
      if (!nrst)
      begin
         in_service_low  <= 1'b0;
         in_service_high <= 1'b0;
      end
      else if (take)
      begin
         if (win_hi)
            in_service_high <= 1'b1;
         else
            in_service_low <= 1'b1;
      end
      else if (core_return)
      begin
         // return ends the innermost routine first
         if (in_service_high)
            in_service_high <= 1'b0;
         else
            in_service_low <= 1'b0;
      end
   end
endmodule // mirl_irq_logic

// ==== tb/mirl_irq_logic_properties.sv ====
`timescale 1ns/1ps
// ==========================================
// checker on the controller ports
module mirl_irq_logic_properties (
   // clock and reset
   input wire       clk_sys, nrst,
   // inputs watched
   input wire       timer_zero_overflow, timer_two_overflow_clr, ext0_trigger_type,
   input wire       ext_request_zero_n, global_irq_enable, core_vector_ack,
   input wire [1:0] timer_zero_mode,
   input wire [9:0] irq_enable_bits,
   // outputs watched
   input wire       timer_zero_overflow_flag, timer_two_overflow_flag, ext0_pending_flag,
   input wire       irq_request, in_service_high,
   input wire [3:0] irq_source
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // an accepted vector of any source
   wire ack_ok = core_vector_ack && irq_request;
   property p_t0_set;
      timer_zero_overflow && timer_zero_mode != 2'h3 |=> timer_zero_overflow_flag;
   endproperty
   property p_t0_mode3;
      !timer_zero_overflow_flag && (timer_zero_mode == 2'h3 || !timer_zero_overflow)
      |=> !timer_zero_overflow_flag;
   endproperty
   property p_t0_clr;
      ack_ok && irq_source == 4'h2 && !timer_zero_overflow |=> !timer_zero_overflow_flag;
   endproperty
   property p_t2_hold;
      timer_two_overflow_flag && !timer_two_overflow_clr |=> timer_two_overflow_flag;
   endproperty
   property p_ext0_edge;
      ext0_trigger_type && ack_ok && irq_source == 4'h0 |=> !ext0_pending_flag;
   endproperty
   property p_ext0_lvl;
      !ext0_trigger_type && ack_ok && irq_source == 4'h0 && !ext_request_zero_n
      && $past(ext_request_zero_n) == 1'b0 && $past(ext_request_zero_n, 2) == 1'b0
      |=> ext0_pending_flag;
   endproperty
   property p_gate;
      !global_irq_enable |-> !irq_request;
   endproperty
   property p_enable;
      irq_request |-> irq_enable_bits[irq_source];
   endproperty
   property p_hi_block;
      in_service_high |-> !irq_request;
   endproperty
   a_t0_set:
      assert property (p_t0_set) else $error("timer zero flag not set");
   a_t0_mode3:
      assert property (p_t0_mode3) else $error("timer zero flag set in mode three");
   a_t0_clr:
      assert property (p_t0_clr) else $error("timer zero flag kept after vector");
   a_t2_hold:
      assert property (p_t2_hold) else $error("timer two flag cleared by hardware");
   a_ext0_edge:
      assert property (p_ext0_edge) else $error("edge flag kept after vector");
   a_ext0_lvl:
      assert property (p_ext0_lvl) else $error("level flag cleared by vector");
   a_gate:
      assert property (p_gate) else $error("request with global enable off");
   a_enable:
      assert property (p_enable) else $error("request from disabled source");
   a_hi_block:
      assert property (p_hi_block) else $error("request during high routine");
   c_ack: cover property (ack_ok);
   c_high: cover property (in_service_high);
   c_t2: cover property (timer_two_overflow_flag);
endmodule // mirl_irq_logic_properties
bind mirl_irq_logic mirl_irq_logic_properties i_mirl_irq_logic_properties (.*);

// ==== tb/mirl_core_model.sv ====
`timescale 1ns/1ps
// ==========================================
// core model: vectors after lat cycles, returns later
module mirl_core_model (
   input wire       clk_sys, nrst, run, irq_request,
   input wire [3:0] irq_source, lat,
   output reg       core_vector_ack, core_return,
   output reg [3:0] vec_src
);
   reg [4:0] cnt; // wait or service count
   reg       busy; // routine running
   // one routine at a time, no nesting
   always @(negedge clk_sys or negedge nrst)
      if (!nrst)
      begin
         {core_vector_ack, core_return, busy, cnt, vec_src} <= 0;
      end
      else
      begin
         core_vector_ack <= 1'b0;
         core_return <= 1'b0;
         cnt <= cnt + 5'h1;
         if (busy && cnt == 5'h6)
            {core_return, busy, cnt} <= {2'b10, 5'h0};
         else if (!busy && !(run && irq_request))
            cnt <= 5'h0;
         else if (!busy && cnt >= {1'b0, lat})
            {core_vector_ack, busy, cnt, vec_src} <= {2'b11, 5'h0, irq_source};
      end
endmodule // mirl_core_model

// ==== tb/mirl_irq_logic_tb.sv ====
`timescale 1ns/1ps
module mirl_irq_logic_tb;
   // ==========================================
   // stimulus and observation
   reg clk_sys = 0, nrst = 0, run = 0;
   reg ext_request_zero_n = 1, ext_request_one_n = 1, timer_two_ext_trigger_n = 1;
   reg ext0_trigger_type = 0, ext1_trigger_type = 0, adc_takes_ext1 = 0, adc_done = 0;
   reg timer_zero_overflow = 0, timer_one_overflow = 0, timer_two_overflow = 0;
   reg timer_two_ext_trigger_enable = 0, timer_two_overflow_clr = 0;
   reg timer_two_ext_trigger_clr = 0, global_irq_enable = 1;
   reg [1:0] timer_zero_mode = 0;
   reg [3:0] lat = 0;
   reg [4:0] pr = 0;
   reg [9:0] irq_enable_bits = 10'h3ff, irq_priority_bits = 10'h000;
   wire uart2_req = pr[0], twb_req = pr[1], ddc_req = pr[2], usb_req = pr[3];
   wire uart1_req = pr[4];
   wire core_vector_ack, core_return, irq_request, irq_high_level;
   wire ext0_pending_flag, ext1_pending_flag, timer_zero_overflow_flag;
   wire timer_one_overflow_flag, timer_two_overflow_flag, timer_two_ext_trigger_flag;
   wire in_service_low, in_service_high;
   wire [3:0] irq_source, vec_src;
   integer err_total = 0, num_checks = 0, i;
   mirl_irq_logic i_mirl_irq_logic (.*);
   mirl_core_model i_mirl_core_model (.*);
   initial forever #5 clk_sys = ~clk_sys;
   // ==========================================
   // helpers
   task tick(input integer n);
      repeat (n) @(negedge clk_sys);
   endtask
   task chk(input [9:0] s, input [9:0] e, input string nm);
      num_checks = num_checks + 1;
      if (s !== e)
      begin
         err_total = err_total + 1;
         $display("unexpected %0s expected %h seen %h", nm, e, s);
      end
   endtask
   task wait_ack; // bounded wait for a vector
      integer k;
      k = 0;
      @(posedge clk_sys);
      while (core_vector_ack !== 1'b1 && k < 50)
      begin
         @(posedge clk_sys);
         k = k + 1;
      end
      chk(k < 50, 1, "vector");
      @(negedge clk_sys);
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      #100000 err_total = err_total + 1;
      finish_test;
   end
   // ==========================================
   // test sequence
   initial
   begin
      tick(10);
      nrst = 1;
      tick(1);
      chk({irq_request, ext0_pending_flag, timer_two_overflow_flag}, 0, "reset");
      for (i = 0; i < 5; i = i + 1)
      begin
         pr = 5'h1 << i;
         tick(1);
         chk(irq_source, (i < 4) ? 2 * i + 1 : 8, "peripheral");
      end
      pr = 0;
      {timer_zero_overflow, timer_one_overflow} = 2'b11;
      tick(1);
      {timer_zero_overflow, timer_one_overflow} = 2'b00;
      chk(irq_source, 2, "poll order");
      irq_priority_bits[6] = 1;
      tick(1);
      chk(irq_source, 6, "high first");
      chk(irq_high_level, 1, "high level");
      global_irq_enable = 0;
      tick(1);
      chk(irq_request, 0, "global off");
      global_irq_enable = 1;
      run = 1;
      wait_ack;
      chk(vec_src, 6, "first vector");
      chk(in_service_high, 1, "high in service");
      wait_ack;
      run = 0;
      chk(vec_src, 2, "second vector");
      chk({in_service_high, in_service_low}, 1, "low in service");
      chk({timer_zero_overflow_flag, timer_one_overflow_flag}, 0, "timer clear");
      timer_zero_mode = 2'h3;
      timer_zero_overflow = 1;
      tick(1);
      timer_zero_overflow = 0;
      chk(timer_zero_overflow_flag, 0, "mode three");
      timer_two_overflow = 1;
      tick(1);
      timer_two_overflow = 0;
      run = 1;
      wait_ack;
      run = 0;
      chk(timer_two_overflow_flag, 1, "timer two kept");
      timer_two_overflow_clr = 1;
      tick(1);
      timer_two_overflow_clr = 0;
      chk(timer_two_overflow_flag, 0, "timer two clr");
      for (i = 0; i < 2; i = i + 1)
      begin
         timer_two_ext_trigger_enable = i;
         timer_two_ext_trigger_n = 0;
         tick(4);
         chk(timer_two_ext_trigger_flag, i, "trigger");
         timer_two_ext_trigger_n = 1;
         tick(2);
      end
      timer_two_ext_trigger_clr = 1;
      tick(1);
      timer_two_ext_trigger_clr = 0;
      ext0_trigger_type = 1;
      ext_request_zero_n = 0;
      tick(4);
      chk(ext0_pending_flag, 1, "edge set");
      run = 1;
      wait_ack;
      chk(ext0_pending_flag, 0, "edge clr");
      run = 0;
      ext_request_zero_n = 1;
      ext0_trigger_type = 0;
      lat = 5;
      tick(4);
      ext_request_zero_n = 0;
      run = 1;
      wait_ack;
      run = 0;
      chk(ext0_pending_flag, 1, "level kept");
      ext_request_zero_n = 1;
      tick(4);
      chk(ext0_pending_flag, 0, "level follows");
      adc_takes_ext1 = 1;
      adc_done = 1;
      tick(1);
      adc_done = 0;
      chk(ext1_pending_flag, 1, "converter");
      run = 1;
      wait_ack;
      chk(vec_src, 4, "converter vector");
      chk(ext1_pending_flag, 0, "converter clr");
      // ext one pin back in charge, sensed on its falling edge
      adc_takes_ext1 = 0;
      ext1_trigger_type = 1;
      ext_request_one_n = 0;
      tick(4);
      chk(ext1_pending_flag, 1, "ext one edge");
      wait_ack;
      chk(vec_src, 4, "ext one vector");
      chk(ext1_pending_flag, 0, "ext one clr");
      run = 0;
      tick(20);
      finish_test;
   end
endmodule // mirl_irq_logic_tb
